// ===== logic/arsxs_defs.svh
// Constants for the rotate/subtract/xor/swap datapath slice.
// Assumes inclusion by bare name from the package and the datapath module.
`ifndef ARSXS_DEFS_SVH
`define ARSXS_DEFS_SVH

`define ARSXS_DATA_W      8
`define ARSXS_ADDR_W      7
`define ARSXS_NIB_LO_MSB  3
`define ARSXS_NIB_HI_LSB  4
`define ARSXS_DEST_ACC    1'b0
`define ARSXS_DEST_FILE   1'b1
`define ARSXS_ACC_RST     8'h00
`define ARSXS_FLAG_RST    1'b0

`endif

// ===== logic/arsxs_pkg.sv
// Types shared by the datapath slice and its bench.
// Assumes arsxs_defs.svh is on the include path.
package arsxs_pkg;
  `include "arsxs_defs.svh"

  typedef enum logic [5:0] {
    ARSXS_OP_ROTATE_RIGHT_THROUGH_CARRY  = 6'b00_0001,
    ARSXS_OP_SUBTRACT_ACC_FROM_IMMEDIATE = 6'b00_0010,
    ARSXS_OP_SUBTRACT_ACC_FROM_FILE      = 6'b00_0100,
    ARSXS_OP_XOR_ACC_WITH_FILE           = 6'b00_1000,
    ARSXS_OP_NIBBLE_EXCHANGE             = 6'b01_0000,
    ARSXS_OP_XOR_IMMEDIATE_INTO_ACC      = 6'b10_0000
  } arsxs_op_t;

  // One issued instruction
  typedef struct packed {
    arsxs_op_t                  op;
    logic [`ARSXS_DATA_W-1:0]   imm;
    logic [`ARSXS_ADDR_W-1:0]   faddr;
    logic                       dest;
    logic [`ARSXS_DATA_W-1:0]   fdata;
  } arsxs_req_t;

  // Status flags
  typedef struct packed {
    logic carry;
    logic half_carry_flag;
    logic zero;
  } arsxs_flags_t;

  // Write-back to the file register
  typedef struct packed {
    logic                       we;
    logic [`ARSXS_ADDR_W-1:0]   addr;
    logic [`ARSXS_DATA_W-1:0]   data;
  } arsxs_fwr_t;
endpackage

// ===== logic/arsxs_alu.sv
// Datapath slice: rotate right through carry, two subtracts, two xors, swap.
// Assumes decode presents one instruction per cycle with the file operand already read,
// and that the register file applies the write-back port one cycle later.
`timescale 1ns/10ps
`include "arsxs_defs.svh"

// Behaviour
// - Rotate right: old carry into bit 7, bit 0 into carry, only carry changes.
// - File address 0..127; destination 0 is accumulator, 1 is the file register.
// - Immediate minus accumulator into accumulator; carry, half carry mean no borrow.
// - File minus accumulator to destination; carry, half carry mean no borrow.
// - Accumulator xor file to destination; only zero flag updates.
// - Swap nibbles of file operand to destination; no flags change.
// - Accumulator xor immediate into accumulator; only zero flag updates.
module arsxs_alu (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  // Instruction in
  input  wire logic                     req_valid,
  input  wire arsxs_pkg::arsxs_req_t    req,
  // Architectural state out
  output logic [`ARSXS_DATA_W-1:0]      acc,
  output arsxs_pkg::arsxs_flags_t       flags,
  output arsxs_pkg::arsxs_fwr_t         file_wr
);
  import arsxs_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  // Architectural state and its next values
  logic [`ARSXS_DATA_W-1:0]     acc_r;
  logic [`ARSXS_DATA_W-1:0]     acc_nxt;
  arsxs_flags_t                 flags_r;
  arsxs_flags_t                 flags_nxt;
  arsxs_fwr_t                   fwr_r;
  arsxs_fwr_t                   fwr_nxt;

  // Decoded strobes
  logic                         do_rot;
  logic                         do_subl;
  logic                         do_subf;
  logic                         do_xorf;
  logic                         do_swap;
  logic                         do_xorl;
  logic                         do_any;
  logic                         use_imm;
  logic                         to_acc;
  logic                         upd_borrow;
  logic                         upd_zero;

  // Operand and per-bit datapath
  logic [`ARSXS_DATA_W-1:0]     opnd;
  logic [`ARSXS_DATA_W-1:0]     diff;
  logic [`ARSXS_DATA_W:0]       borrow;
  logic [`ARSXS_DATA_W-1:0]     xored;
  logic [`ARSXS_DATA_W-1:0]     rotated;
  logic [`ARSXS_DATA_W-1:0]     swapped;
  logic [`ARSXS_DATA_W-1:0]     result;
  logic                         res_zero;

  // ----------------------------------------------------------------
  // Operation decode
  // ----------------------------------------------------------------
  // A code that is not one-hot raises no strobe, so the instruction is dropped
  always_comb begin
    do_rot  = 1'b0;
    do_subl = 1'b0;
    do_subf = 1'b0;
    do_xorf = 1'b0;
    do_swap = 1'b0;
    do_xorl = 1'b0;
    if (req_valid) begin
      unique case (req.op)
        ARSXS_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
          do_rot = 1'b1;
        end
        ARSXS_OP_SUBTRACT_ACC_FROM_IMMEDIATE: begin
          do_subl = 1'b1;
        end
        ARSXS_OP_SUBTRACT_ACC_FROM_FILE: begin
          do_subf = 1'b1;
        end
        ARSXS_OP_XOR_ACC_WITH_FILE: begin
          do_xorf = 1'b1;
        end
        ARSXS_OP_NIBBLE_EXCHANGE: begin
          do_swap = 1'b1;
        end
        ARSXS_OP_XOR_IMMEDIATE_INTO_ACC: begin
          do_xorl = 1'b1;
        end
        default: begin
          // Illegal code: nothing is executed
          do_rot = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    do_any     = do_rot | do_subl | do_subf | do_xorf | do_swap | do_xorl;
    // Literal forms never carry a destination select
    use_imm    = do_subl | do_xorl;
    to_acc     = use_imm | (req.dest == `ARSXS_DEST_ACC);
    upd_borrow = do_subl | do_subf;
    upd_zero   = do_subl | do_subf | do_xorf | do_xorl;
  end

  // ----------------------------------------------------------------
  // Per-bit datapath
  // ----------------------------------------------------------------
  // One borrow chain serves both subtracts; the borrow out of bit 3 gives
  // the half carry without a second, narrow subtractor.
  assign opnd      = use_imm ? req.imm : req.fdata;
  assign borrow[0] = 1'b0;

  for (genvar i = 0; i < `ARSXS_DATA_W; i++) begin : g_bit
    // Operand minus accumulator, one bit at a time
    assign diff[i]     = opnd[i] ^ acc_r[i] ^ borrow[i];
    assign borrow[i+1] = (~opnd[i] & acc_r[i]) | (~(opnd[i] ^ acc_r[i]) & borrow[i]);
    assign xored[i]    = acc_r[i] ^ opnd[i];
  end

  // Rotate and swap are pure wiring of the file operand, plus the carry flag for rotate
  assign rotated = {flags_r.carry, req.fdata[`ARSXS_DATA_W-1:1]};
  assign swapped = {req.fdata[`ARSXS_NIB_LO_MSB:0],
                    req.fdata[`ARSXS_DATA_W-1:`ARSXS_NIB_HI_LSB]};

  // ----------------------------------------------------------------
  // Result select
  // ----------------------------------------------------------------
  always_comb begin
    result = '0;
    if (do_rot) begin
      result = rotated;
    end else if (upd_borrow) begin
      result = diff;
    end else if (do_xorf || do_xorl) begin
      result = xored;
    end else if (do_swap) begin
      result = swapped;
    end
    res_zero = (result == '0);
  end

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  always_comb begin
    acc_nxt = acc_r;
    if (do_any && to_acc) begin
      acc_nxt = result;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      acc_r <= `ARSXS_ACC_RST;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Swap touches no flag, rotate only carry, the two xors only zero.
  always_comb begin
    flags_nxt = flags_r;
    if (do_rot) begin
      flags_nxt.carry = req.fdata[0];
    end
    if (upd_borrow) begin
      // Carry and half carry read as no borrow
      flags_nxt.carry           = ~borrow[`ARSXS_DATA_W];
      flags_nxt.half_carry_flag = ~borrow[`ARSXS_NIB_HI_LSB];
    end
    if (upd_zero) begin
      flags_nxt.zero = res_zero;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flags_r.carry           <= `ARSXS_FLAG_RST;
      flags_r.half_carry_flag <= `ARSXS_FLAG_RST;
      flags_r.zero            <= `ARSXS_FLAG_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ----------------------------------------------------------------
  // File register write-back
  // ----------------------------------------------------------------
  // A one-cycle strobe; the register file owns storage and the read path.
  // Limitation: no forwarding here, so decode must hand over fresh file data
  // when an instruction reads the address that the previous one wrote.
  always_comb begin
    fwr_nxt = '0;
    if (do_any && !to_acc) begin
      fwr_nxt.we   = 1'b1;
      fwr_nxt.addr = req.faddr;
      fwr_nxt.data = result;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fwr_r <= '0;
    end else begin
      fwr_r <= fwr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign acc     = acc_r;
  assign flags   = flags_r;
  assign file_wr = fwr_r;
endmodule

// ===== test/arsxs_alu_properties.sv
// Port checker for the arsxs datapath slice.
// Assumes arsxs_pkg is compiled first; bound below.
`timescale 1ns/10ps
module arsxs_alu_chk (
  // Clock and reset
  input wire logic                    clk_sys,
  input wire logic                    reset_n,
  // Instruction and state
  input wire logic                    req_valid,
  input wire arsxs_pkg::arsxs_req_t   req,
  input wire logic [7:0]              acc,
  input wire arsxs_pkg::arsxs_flags_t flags,
  input wire arsxs_pkg::arsxs_fwr_t   file_wr
);
  import arsxs_pkg::*;
  // Refused requests clear every op bit
  wire logic [5:0] k = req_valid && $onehot(req.op) ? req.op : 6'h00;
  wire logic [7:0] res = file_wr.we ? file_wr.data : acc;
  arsxs_req_t      p;
  logic [7:0]      pa;
  arsxs_flags_t    pf;
  always_ff @(posedge clk_sys) begin
    p  <= req;
    pa <= acc;
    pf <= flags;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_rot_result: assert property (
    k[0] |=> res == {pf.carry, p.fdata[7:1]} && flags == {p.fdata[0], pf[1:0]}) else $error("rot");
  a_dest_select: assert property (
    (k[0] | k[2] | k[3] | k[4]) |=> file_wr.we == p.dest
    && (!p.dest || acc == pa && file_wr.addr == p.faddr)) else $error("dest");
  a_sub_imm: assert property (
    k[1] |=> acc == p.imm - pa && !file_wr.we
    && flags[2:1] == {pa <= p.imm, pa[3:0] <= p.imm[3:0]}) else $error("subl");
  a_sub_file: assert property (
    k[2] |=> res == p.fdata - pa
    && flags[2:1] == {pa <= p.fdata, pa[3:0] <= p.fdata[3:0]}) else $error("subf");
  a_xor_file: assert property (
    k[3] |=> res == (pa ^ p.fdata) && flags[2:1] == pf[2:1]) else $error("xorf");
  a_swap_keep: assert property (
    k[4] |=> res == {p.fdata[3:0], p.fdata[7:4]} && flags == pf) else $error("swap");
  a_xor_imm: assert property (
    k[5] |=> acc == (pa ^ p.imm) && !file_wr.we && flags[2:1] == pf[2:1]) else $error("xorl");
  a_zero_flag: assert property (
    (k[1] | k[2] | k[3] | k[5]) |=> flags.zero == (res == 8'h00)) else $error("zero");
endmodule
bind arsxs_alu arsxs_alu_chk u_chk (.clk_sys, .reset_n, .req_valid, .req, .acc, .flags, .file_wr);

// ===== test/testbench.sv
// Bench for the arsxs datapath: random, then directed instructions.
// Assumes package, datapath and bound checker compile first.
`timescale 1ns/10ps
module testbench;
  import arsxs_pkg::*;
  typedef struct packed {logic [7:0] a; arsxs_flags_t f; arsxs_fwr_t w;} arsxs_exp_t;
  logic         clk_sys, reset_n, req_valid;
  logic [7:0]   acc, m_a;
  arsxs_req_t   req;
  arsxs_flags_t flags, m_f;
  arsxs_fwr_t   file_wr;
  arsxs_exp_t   q[$], x;
  int           n_mismatch, tests_run, sel;
  arsxs_alu dut (.clk_sys, .reset_n, .req_valid, .req, .acc, .flags, .file_wr);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic cmp_state(logic [11:0] e, g);
    tests_run++;
    if (e !== g) begin
      n_mismatch++;
      $display("unexpected state: expected %h, seen %h", e, g);
    end
  endtask
  task automatic cmp_fwr(logic [14:0] e, g);
    tests_run++;
    if (e !== g) begin
      n_mismatch++;
      $display("unexpected file_wr: expected %h, seen %h", e, g);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // o: 0 rot, 1 sub imm, 2 sub file, 3 xor file, 4 swap, 5 xor imm, above 5 illegal
  task automatic issue(logic v, int o, logic [7:0] im, fd, logic [6:0] fa, logic d);
    arsxs_exp_t e;
    logic [7:0] s, r;
    e = '{m_a, m_f, '0};
    s = (o == 1 || o == 5) ? im : fd;
    case (o)
      0: r = {m_f.carry, fd[7:1]};
      3, 5: r = m_a ^ s;
      4: r = {fd[3:0], fd[7:4]};
      default: r = s - m_a;
    endcase
    if (o == 0) e.f.carry = fd[0];
    if (o == 1 || o == 2) e.f[2:1] = {m_a <= s, m_a[3:0] <= s[3:0]};
    if (o != 0 && o != 4) e.f.zero = r == 8'h00;
    e.w = '{d && o != 1 && o != 5, fa, r};
    e.a = e.w.we ? m_a : r;
    if (!v || o > 5) e = '{m_a, m_f, '0};
    m_a = e.a;
    m_f = e.f;
    @(posedge clk_sys);
    req_valid <= v;
    req <= '{o > 5 ? arsxs_op_t'(6'h03) : arsxs_op_t'(6'h01 << o), im, fa, d, fd};
    @(negedge clk_sys);
    q.push_back(e);
  endtask
  always @(posedge clk_sys) begin
    if (q.size() > 0) begin
      x = q.pop_front();
      #1;
      cmp_state({x.a, x.f, x.w.we}, {acc, flags, file_wr.we});
      if (x.w.we) cmp_fwr({x.w.addr, x.w.data}, {file_wr.addr, file_wr.data});
    end
  end
  initial begin
    reset_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    m_a = 8'h00;
    m_f = '0;
    void'($urandom(60));
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int i = 0; i < 300; i++) begin
      sel = $urandom % 8;
      issue(sel != 7, sel, 8'($urandom), 8'($urandom), 7'($urandom), 1'($urandom));
    end
    $display("random test done");
    issue(1, 5, m_a ^ 8'h03, 8'h00, 7'h00, 1'b0);
    issue(1, 2, 8'h00, 8'h05, 7'h7f, 1'b1);
    issue(1, 2, 8'h00, 8'h02, 7'h00, 1'b0);
    issue(1, 1, 8'hff, 8'h00, 7'h00, 1'b0);
    issue(1, 0, 8'h00, 8'h01, 7'h7f, 1'b1);
    issue(1, 3, 8'h00, m_a, 7'h00, 1'b0);
    issue(0, 0, 8'h00, 8'h00, 7'h00, 1'b0);
    repeat (2) @(posedge clk_sys);
    $display("directed test done");
    end_sim;
  end
  initial begin
    repeat (2000) @(posedge clk_sys);
    n_mismatch++;
    end_sim;
  end
endmodule
